//--- src/iodt_top.sv
// Function
// - Output pins read back their actual level
// - Switchable pull-ups on pins 4-7, 11
// - Low-level detect latches on pins 0-7
// - Timer has load, counter, capture latch
// - Timer registers accessed one byte each
// - Timer 1 input pins 4-7, output pin 0
// - Timer 2 input pin 4, output pin 1
// - Unused timer output pin stays general purpose
// - Clock: pin or scaled clock; enable: pin or always on
// - Timer clock rates set independently
// - External clock edge: rise, fall, both
// - System clock is half oscillator input
`timescale 1ns/1ps
`default_nettype none
module iodt_top #(
	// Pin count of the port
	parameter int unsigned NUM_PINS = iodt_pkg::NUM_PINS,
	// Width of the divider selects
	parameter int unsigned PRESC_W = iodt_pkg::PRESC_W,
	// Width of one timer access
	parameter int unsigned BYTE_W = iodt_pkg::BYTE_W
) (
	// Clock, reset, enable
	// Core clock, twice the system clock
	input wire logic core_clk,
	// Asynchronous reset, active high
	input wire logic rst,
	// Low freezes every register
	input wire logic clk_en,

	// Pins: output enable low while driving
	// Pad levels, taken as synchronous
	input wire logic [NUM_PINS-1:0] pin_in,
	// Registered drive value
	output logic [NUM_PINS-1:0] pin_out,
	// Registered output enable, low drives
	output logic [NUM_PINS-1:0] pin_oe_n,
	// Registered pull-up switch
	output logic [NUM_PINS-1:0] pin_pullup_en,

	// General purpose port control
	// Value driven on output pins
	input wire logic [NUM_PINS-1:0] gp_out_val,
	// High makes the pin an output
	input wire logic [NUM_PINS-1:0] gp_dir_out,
	// Pull-up request, ignored where none exists
	input wire logic [NUM_PINS-1:0] gp_pullup_cfg,
	// Pad level, one cycle late
	output logic [NUM_PINS-1:0] gp_read_val,

	// Low level detect latches
	// Clear per latch
	input wire logic [7:0] detect_clr,
	// Sticky low seen
	output logic [7:0] detect_flag,

	// Timer 1 configuration
	// Input pin offset from pin 4
	input wire logic [1:0] t1_in_sel,
	// Clock from pin or scaled clock
	input wire logic t1_clk_src,
	// Enable from pin or always on
	input wire logic t1_en_src,
	// Pin level that lets it count
	input wire logic t1_en_level,
	// Pin edge that counts
	input wire logic [1:0] t1_edge_sel,
	// Divider select for the scaled clock
	input wire logic [PRESC_W-1:0] t1_div_sel,
	// Hands pin 0 to the timer
	input wire logic t1_out_en,
	// Copies the counter into the latch
	input wire logic t1_capture,

	// Timer 2 configuration
	// Clock from pin or scaled clock
	input wire logic t2_clk_src,
	// Enable from pin or always on
	input wire logic t2_en_src,
	// Pin level that lets it count
	input wire logic t2_en_level,
	// Pin edge that counts
	input wire logic [1:0] t2_edge_sel,
	// Divider select for the scaled clock
	input wire logic [PRESC_W-1:0] t2_div_sel,
	// Hands pin 1 to the timer
	input wire logic t2_out_en,
	// Copies the counter into the latch
	input wire logic t2_capture,

	// Timer byte access
	// Write one load byte
	input wire logic tmr_wr_stb,
	// Read one latch byte
	input wire logic tmr_rd_stb,
	// Low picks timer 1, high timer 2
	input wire logic tmr_sel,
	// Low or high byte
	input wire logic tmr_byte_sel,
	// Byte to write
	input wire logic [BYTE_W-1:0] tmr_wr_data,
	// Timer 1 latch byte, held until its next read
	output logic [BYTE_W-1:0] t1_rd_data,
	// Timer 2 latch byte, held until its next read
	output logic [BYTE_W-1:0] t2_rd_data
);
	typedef struct packed {
		logic half; // System clock phase
		logic [NUM_PINS-1:0] pin_prev; // Last pin level, for edge detection
		logic [NUM_PINS-1:0] rdback; // Pin read-back
		logic [7:0] detect; // Sticky low detects
		// Registered pin drive values
		logic [NUM_PINS-1:0] dout;
		// Registered output enables, low drives
		logic [NUM_PINS-1:0] oe_n;
		// Registered pull-up switches
		logic [NUM_PINS-1:0] pull;
	} iodt_top_s;
	iodt_top_s st_q, st_d;

	// Edge qualifier shared by both timers
	function automatic logic edge_hit(input logic cur, input logic prev, input logic [1:0] sel);
		// Low to high since the last sample
		logic rise;
		// High to low since the last sample
		logic fall;
		rise = cur & ~prev;
		fall = ~cur & prev;
		// Unused code counts rising edges rather than nothing
		case (sel)
			iodt_pkg::EDGE_RISE: edge_hit = rise;
			iodt_pkg::EDGE_FALL: edge_hit = fall;
			iodt_pkg::EDGE_BOTH: edge_hit = rise | fall;
			default: edge_hit = rise;
		endcase
	endfunction

	// System clock tick, every second core cycle
	logic sys_tick;
	// Timer 1 divider tick
	logic t1_scaled;
	// Timer 2 divider tick
	logic t2_scaled;
	// Selected timer 1 input pin
	logic t1_pin;
	// Its level one cycle earlier
	logic t1_pin_prev;
	// Timer 1 count tick
	logic t1_tick;
	// Timer 2 count tick
	logic t2_tick;
	// Timer 1 count enable
	logic t1_en;
	// Timer 2 count enable
	logic t2_en;
	// Timer 1 output level
	logic t1_lvl;
	// Timer 2 output level
	logic t2_lvl;
	// Timer 1 byte write
	logic t1_wr;
	// Timer 2 byte write
	logic t2_wr;
	// Timer 1 byte read
	logic t1_rd;
	// Timer 2 byte read
	logic t2_rd;

	// System clock tick is every second core cycle
	// A tick rather than a divided clock keeps one clock domain
	assign sys_tick = st_q.half;

	// Timer 1 input mux over pins 4..7
	// Pins are sampled once per core cycle, so a pulse shorter
	// than one cycle can be missed by the edge detector
	assign t1_pin = pin_in[iodt_pkg::T1_IN_BASE + t1_in_sel];
	assign t1_pin_prev = st_q.pin_prev[iodt_pkg::T1_IN_BASE + t1_in_sel];

	// Clock source and enable selection per timer
	always_comb begin
		// Timer 1: edge of the chosen pin or its own divider
		t1_tick = (t1_clk_src == iodt_pkg::CLK_SRC_PIN) ? edge_hit(t1_pin, t1_pin_prev, t1_edge_sel) : t1_scaled;
		// Timer 2: edge of its fixed pin or its own divider
		t2_tick = (t2_clk_src == iodt_pkg::CLK_SRC_PIN) ?
			edge_hit(pin_in[iodt_pkg::T2_IN_PIN], st_q.pin_prev[iodt_pkg::T2_IN_PIN], t2_edge_sel) : t2_scaled;
		// Pin enable gates counting by a level; scaled source means always on
		t1_en = (t1_en_src == iodt_pkg::CLK_SRC_PIN) ? (t1_pin == t1_en_level) : 1'b1;
		t2_en = (t2_en_src == iodt_pkg::CLK_SRC_PIN) ? (pin_in[iodt_pkg::T2_IN_PIN] == t2_en_level) : 1'b1;
	end

	// Byte strobes steered to the selected timer
	// Timer 1 answers when the select is low
	assign t1_wr = tmr_wr_stb & ~tmr_sel;
	assign t2_wr = tmr_wr_stb & tmr_sel;
	// Reads steer the same way
	assign t1_rd = tmr_rd_stb & ~tmr_sel;
	assign t2_rd = tmr_rd_stb & tmr_sel;

	// A shared divider would tie one rate to the other
	// Separate dividers keep the two rates independent
	iodt_prescaler #(.PRESC_W(PRESC_W)) u_presc1 (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.sys_tick(sys_tick),
		.div_sel(t1_div_sel),
		.scaled_tick(t1_scaled)
	);

	iodt_prescaler #(.PRESC_W(PRESC_W)) u_presc2 (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.sys_tick(sys_tick),
		.div_sel(t2_div_sel),
		.scaled_tick(t2_scaled)
	);

	// Both timers share one byte port; the select steers strobes
	// Timer 1
	iodt_timer #(.CNT_W(iodt_pkg::CNT_W), .BYTE_W(BYTE_W)) u_tmr1 (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.count_tick(t1_tick),
		.count_en(t1_en),
		.capture(t1_capture),
		.wr_stb(t1_wr),
		.rd_stb(t1_rd),
		.byte_sel(tmr_byte_sel),
		.wr_data(tmr_wr_data),
		.rd_data(t1_rd_data),
		.tmr_out(t1_lvl)
	);

	// Timer 2, same structure, fixed pins
	// Timer 2
	iodt_timer #(.CNT_W(iodt_pkg::CNT_W), .BYTE_W(BYTE_W)) u_tmr2 (
		.core_clk(core_clk),
		.rst(rst),
		.clk_en(clk_en),
		.count_tick(t2_tick),
		.count_en(t2_en),
		.capture(t2_capture),
		.wr_stb(t2_wr),
		.rd_stb(t2_rd),
		.byte_sel(tmr_byte_sel),
		.wr_data(tmr_wr_data),
		.rd_data(t2_rd_data),
		.tmr_out(t2_lvl)
	);

	// Pin drive, pull-ups, read-back and detect latches
	always_comb begin
		st_d = st_q;
		st_d.half = ~st_q.half;
		// Last sample for the edge detectors
		st_d.pin_prev = pin_in;
		// Read-back takes the pad, so a driven pin shows its real level
		st_d.rdback = pin_in;
		// General drive first, timers may take pins 0 and 1 below
		st_d.dout = gp_out_val;
		// Direction high drives, so the enable is its inverse
		st_d.oe_n = ~gp_dir_out;
		// Timer outputs take their pin only when enabled, else it stays general
		if (t1_out_en) begin
			st_d.dout[iodt_pkg::T1_OUT_PIN] = t1_lvl;
			st_d.oe_n[iodt_pkg::T1_OUT_PIN] = 1'b0;
		end
		if (t2_out_en) begin
			st_d.dout[iodt_pkg::T2_OUT_PIN] = t2_lvl;
			st_d.oe_n[iodt_pkg::T2_OUT_PIN] = 1'b0;
		end
		// Pins without a current source ignore the request
		st_d.pull = gp_pullup_cfg & iodt_pkg::PULLUP_MASK;
		// Set wins over clear so a low in the clear cycle is kept
		st_d.detect = (st_q.detect & ~detect_clr) | (~pin_in[7:0] & iodt_pkg::DETECT_MASK[7:0]);
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
			// All pins released during reset
			st_q.oe_n <= '1;
			// Idle high assumed, so no false edge after reset
			st_q.pin_prev <= '1;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	// Pin drive from flip-flops
	assign pin_out = st_q.dout;
	// Output enables from flip-flops
	assign pin_oe_n = st_q.oe_n;
	// Pull-up switches from flip-flops
	assign pin_pullup_en = st_q.pull;
	// Read-back, one cycle behind the pad
	assign gp_read_val = st_q.rdback;
	// Sticky detect flags
	assign detect_flag = st_q.detect;
endmodule
`default_nettype wire

//--- src/iodt_pkg.sv
package iodt_pkg;
	// Pin count and fixed pin roles
	localparam int unsigned NUM_PINS = 12;
	localparam int unsigned DETECT_PINS = 8;
	localparam int unsigned T1_OUT_PIN = 0;
	localparam int unsigned T2_OUT_PIN = 1;
	localparam int unsigned T1_IN_BASE = 4;
	localparam int unsigned T2_IN_PIN = 4;
	// Pins carrying a switchable pull-up: 4..7 and 11
	localparam logic [11:0] PULLUP_MASK = 12'h8f0;
	// Pins carrying a low level detect latch: 0..7
	localparam logic [11:0] DETECT_MASK = 12'h0ff;
	// Counter geometry
	localparam int unsigned CNT_W = 16;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned PRESC_W = 4;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	// Byte select codes on the timer access port
	localparam logic BYTE_LO = 1'b0;
	localparam logic BYTE_HI = 1'b1;
	// Edge selection codes for external clocking
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;
	// Clock source codes
	localparam logic CLK_SRC_SCALED = 1'b0;
	localparam logic CLK_SRC_PIN = 1'b1;
	// System clock is half of the oscillator input
	localparam int unsigned SYS_DIV = 2;
endpackage

//--- src/iodt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// Divides the system clock tick by 2^(sel+1) and gives a one-cycle tick
module iodt_prescaler #(
	parameter int unsigned PRESC_W = iodt_pkg::PRESC_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Control
	input wire logic sys_tick,
	input wire logic [PRESC_W-1:0] div_sel,
	// Result
	output logic scaled_tick
);
	typedef struct packed {
		logic [(1<<PRESC_W)-1:0] cnt; // Free running ripple count
	} iodt_presc_s;
	iodt_presc_s st_q, st_d;
	logic [(1<<PRESC_W)-1:0] next_cnt;

	// Each divider owns its own count, so the timers never disturb each other
	always_comb begin
		st_d = st_q;
		next_cnt = st_q.cnt + 1'b1;
		scaled_tick = 1'b0;
		if (sys_tick) begin
			st_d.cnt = next_cnt;
			// Tick when bit div_sel rises, i.e. every 2^(div_sel+1) ticks
			scaled_tick = next_cnt[div_sel] & ~st_q.cnt[div_sel];
		end
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end
endmodule
`default_nettype wire

//--- src/iodt_timer.sv
`timescale 1ns/1ps
`default_nettype none
// One 16-bit timer/counter: load register, counter, capture latch
module iodt_timer #(
	parameter int unsigned CNT_W = iodt_pkg::CNT_W,
	parameter int unsigned BYTE_W = iodt_pkg::BYTE_W
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Count qualifiers
	input wire logic count_tick,
	input wire logic count_en,
	input wire logic capture,
	// Byte access
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic byte_sel,
	input wire logic [BYTE_W-1:0] wr_data,
	output logic [BYTE_W-1:0] rd_data,
	// Output level
	output logic tmr_out
);
	typedef struct packed {
		logic [CNT_W-1:0] load;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] latch;
		logic [BYTE_W-1:0] rdata;
		logic out;
	} iodt_tmr_s;
	iodt_tmr_s st_q, st_d;

	// Count down from load; toggle output on terminal count and reload
	always_comb begin
		st_d = st_q;
		if (wr_stb) begin
			if (byte_sel == iodt_pkg::BYTE_HI) begin
				st_d.load[CNT_W-1:BYTE_W] = wr_data;
			end else begin
				st_d.load[BYTE_W-1:0] = wr_data;
			end
		end
		if (count_tick && count_en) begin
			if (st_q.cnt == iodt_pkg::CNT_RESET) begin
				st_d.cnt = st_q.load;
				st_d.out = ~st_q.out;
			end else begin
				st_d.cnt = st_q.cnt - 1'b1;
			end
		end
		// Capture wins over nothing; software only reads the latch
		if (capture) begin
			st_d.latch = st_q.cnt;
		end
		if (rd_stb) begin
			// Either byte reads the latch, which only capture updates, so the pair stays coherent in any order
			st_d.rdata = (byte_sel == iodt_pkg::BYTE_HI) ? st_q.latch[CNT_W-1:BYTE_W] : st_q.latch[BYTE_W-1:0];
		end
	end

	// State register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign rd_data = st_q.rdata;
	assign tmr_out = st_q.out;
endmodule
`default_nettype wire

//--- dv/iodt_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on pins, detect latches and timer reads
module iodt_props (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Pins
	input wire logic [11:0] pin_in,
	input wire logic [11:0] pin_out,
	input wire logic [11:0] pin_oe_n,
	input wire logic [11:0] pin_pullup_en,
	// Port control
	input wire logic [11:0] gp_out_val,
	input wire logic [11:0] gp_dir_out,
	input wire logic [11:0] gp_pullup_cfg,
	input wire logic [11:0] gp_read_val,
	input wire logic [7:0] detect_clr,
	input wire logic [7:0] detect_flag,
	// Timer side
	input wire logic t1_out_en,
	input wire logic tmr_rd_stb,
	input wire logic [7:0] t1_rd_data,
	input wire logic [7:0] t2_rd_data
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Timer holds pin 0 for two cycles
	sequence s_own;
		t1_out_en [*2];
	endsequence
	// Pins without a pull-up never enable one
	property p_pull; (pin_pullup_en & ~iodt_pkg::PULLUP_MASK) == 12'h000; endproperty
	a_pull: assert property (p_pull) else $error("pull-up on wrong pin");
	property p_pullcfg; !$past(rst) |-> pin_pullup_en == ($past(gp_pullup_cfg) & iodt_pkg::PULLUP_MASK); endproperty
	a_pullcfg: assert property (p_pullcfg) else $error("pull-up not following config");
	property p_rdbk; !$past(rst) |-> gp_read_val == $past(pin_in); endproperty
	a_rdbk: assert property (p_rdbk) else $error("read value not pad level");
	property p_det; !$past(rst) |-> ($past(~pin_in[7:0]) & ~detect_flag) == 8'h00; endproperty
	a_det: assert property (p_det) else $error("low level missed");
	property p_stick; !$past(rst) |-> ($past(detect_flag & ~detect_clr) & ~detect_flag) == 8'h00; endproperty
	a_stick: assert property (p_stick) else $error("detect flag lost");
	// Pins 2..11 are never taken by a timer
	property p_gp; !$past(rst) |-> pin_out[11:2] == $past(gp_out_val[11:2]) && pin_oe_n[11:2] == ~$past(gp_dir_out[11:2]); endproperty
	a_gp: assert property (p_gp) else $error("general pin drive wrong");
	property p_gp0; !$past(rst) && !$past(t1_out_en) && !$past(t1_out_en, 2) |-> pin_oe_n[0] == !$past(gp_dir_out[0]); endproperty
	a_gp0: assert property (p_gp0) else $error("pin 0 not free");
	property p_own; s_own |=> !pin_oe_n[0]; endproperty
	a_own: assert property (p_own) else $error("timer not driving pin 0");
	// Latch bytes move only after a read
	property p_hold; !$past(rst) && !$past(tmr_rd_stb) |-> $stable(t1_rd_data) && $stable(t2_rd_data); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind iodt_top iodt_props u_props (.core_clk, .rst, .pin_in, .pin_out, .pin_oe_n, .pin_pullup_en, .gp_out_val,
	.gp_dir_out, .gp_pullup_cfg, .gp_read_val, .detect_clr, .detect_flag, .t1_out_en, .tmr_rd_stb,
	.t1_rd_data, .t2_rd_data);
`default_nettype wire

//--- dv/iodt_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
// External hardware on the pads
module iodt_pins_model (
	// Clock
	input wire logic core_clk,
	// Device side
	input wire logic [11:0] pin_out,
	input wire logic [11:0] pin_oe_n,
	input wire logic [11:0] pin_pullup_en,
	// Bench side
	input wire logic [11:0] ext_drv,
	input wire logic [11:0] ext_en,
	// Resolved pad level
	output logic [11:0] pin_in
);
	logic [11:0] float_q = 12'h000; // Undriven pads wander
	// Flip every cycle so a stale level is never trusted
	always @(posedge core_clk) begin
		float_q <= ~pin_in;
	end
	// Device drive first, then bench, then pull-up
	always_comb begin
		for (int i = 0; i < 12; i++) begin
			if (!pin_oe_n[i]) begin
				pin_in[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_in[i] = ext_drv[i];
			end else if (pin_pullup_en[i]) begin
				pin_in[i] = 1'b1;
			end else begin
				pin_in[i] = float_q[i];
			end
		end
	end
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk = 1'b0; // 250 MHz
	logic rst = 1'b1;
	logic clk_en = 1'b1; // Freeze not exercised
	logic [11:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, gp_read_val;
	logic [11:0] gp_out_val = 12'h000, gp_dir_out = 12'h000, gp_pullup_cfg = 12'h000;
	logic [11:0] ext_drv = 12'hfff, ext_en = 12'hfff;
	logic [7:0] detect_clr = 8'h00, detect_flag, tmr_wr_data = 8'h00, t1_rd_data, t2_rd_data;
	logic [1:0] t1_in_sel = 2'h0, t1_edge_sel = iodt_pkg::EDGE_BOTH, t2_edge_sel = iodt_pkg::EDGE_RISE;
	logic [3:0] t1_div_sel = 4'h0, t2_div_sel = 4'h1;
	logic t1_clk_src = iodt_pkg::CLK_SRC_PIN, t2_clk_src = iodt_pkg::CLK_SRC_PIN;
	logic t1_en_src = 1'b0, t2_en_src = 1'b0, t1_en_level = 1'b1, t2_en_level = 1'b1;
	logic t1_out_en = 1'b0, t2_out_en = 1'b0, t1_capture = 1'b0, t2_capture = 1'b0;
	logic tmr_wr_stb = 1'b0, tmr_rd_stb = 1'b0, tmr_sel = 1'b0, tmr_byte_sel = 1'b0;
	int fails = 0, n_tests = 0;
	// Rows: out, dir, pull, ext, expected read, expected pull-up
	logic [11:0] rows [3][6] = '{'{12'ha5c, 12'hfff, 12'hfff, 12'h000, 12'ha5c, 12'h8f0},
		'{12'h3c3, 12'h0f0, 12'h000, 12'h5a5, 12'h5c5, 12'h000},
		'{12'h000, 12'h00f, 12'h8f0, 12'hfff, 12'hff0, 12'h8f0}};
	always #2 core_clk = ~core_clk;
	iodt_top dut (.core_clk, .rst, .clk_en, .pin_in, .pin_out, .pin_oe_n, .pin_pullup_en, .gp_out_val,
		.gp_dir_out, .gp_pullup_cfg, .gp_read_val, .detect_clr, .detect_flag, .t1_in_sel, .t1_clk_src,
		.t1_en_src, .t1_en_level, .t1_edge_sel, .t1_div_sel, .t1_out_en, .t1_capture, .t2_clk_src,
		.t2_en_src, .t2_en_level, .t2_edge_sel, .t2_div_sel, .t2_out_en, .t2_capture, .tmr_wr_stb,
		.tmr_rd_stb, .tmr_sel, .tmr_byte_sel, .tmr_wr_data, .t1_rd_data, .t2_rd_data);
	iodt_pins_model u_pins (.core_clk, .pin_out, .pin_oe_n, .pin_pullup_en, .ext_drv, .ext_en, .pin_in);
	// Verdict and end of run
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// One byte into a load register
	task automatic wr(input logic s, input logic b, input logic [7:0] d);
		@(posedge core_clk);
		tmr_wr_stb <= 1'b1;
		tmr_sel <= s;
		tmr_byte_sel <= b;
		tmr_wr_data <= d;
		@(posedge core_clk);
		tmr_wr_stb <= 1'b0;
	endtask
	// Capture both timers, settle
	task automatic cap();
		@(posedge core_clk);
		t1_capture <= 1'b1;
		t2_capture <= 1'b1;
		@(posedge core_clk);
		t1_capture <= 1'b0;
		t2_capture <= 1'b0;
		tick(2);
	endtask
	// Latch read as two bytes, low first
	task automatic rd(input logic s, input logic [15:0] exp);
		logic [15:0] v;
		for (int b = 0; b < 2; b++) begin
			@(posedge core_clk);
			tmr_rd_stb <= 1'b1;
			tmr_sel <= s;
			tmr_byte_sel <= b[0];
			@(posedge core_clk);
			tmr_rd_stb <= 1'b0;
			#1;
			v[8*b +: 8] = s ? t2_rd_data : t1_rd_data;
		end
		chk(v, exp);
	endtask
	// Low then high pulses on pins 4..7
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge core_clk);
			ext_drv[7:4] <= 4'h0;
			tick(3);
			ext_drv[7:4] <= 4'hf;
			tick(3);
		end
		tick(4);
	endtask
	// Cut a hang short
	initial begin
		#20000;
		fails++;
		wrap_up();
	end
	initial begin
		tick(20);
		#1;
		chk({4'h0, pin_oe_n}, 16'h0fff);
		@(posedge core_clk);
		rst <= 1'b0;
		// Pin-clocked timers, t1 both edges, t2 rising only
		wr(1'b0, iodt_pkg::BYTE_LO, 8'h34);
		wr(1'b0, iodt_pkg::BYTE_HI, 8'h12);
		wr(1'b1, iodt_pkg::BYTE_LO, 8'ha0);
		wr(1'b1, iodt_pkg::BYTE_HI, 8'h00);
		pulse(3);
		cap();
		rd(1'b0, 16'h122f);
		rd(1'b1, 16'h009e);
		// Retune t1 only: pin 7, falling edges
		@(posedge core_clk);
		t1_in_sel <= 2'h3;
		t1_edge_sel <= iodt_pkg::EDGE_FALL;
		pulse(3);
		cap();
		rd(1'b0, 16'h122c);
		rd(1'b1, 16'h009b);
		// Hand pins 0 and 1 to the timers and back; each has reloaded once, so both levels are high
		@(posedge core_clk);
		t1_out_en <= 1'b1;
		t2_out_en <= 1'b1;
		tick(3);
		#1;
		chk({14'h0, pin_oe_n[1:0]}, 16'h0000);
		chk({14'h0, pin_out[1:0]}, 16'h0003);
		@(posedge core_clk);
		t1_out_en <= 1'b0;
		t2_out_en <= 1'b0;
		tick(3);
		#1;
		chk({14'h0, pin_oe_n[1:0]}, 16'h0003);
		chk({14'h0, pin_out[1:0]}, 16'h0000);
		// Scaled clocks gated by a low pin: 32 cycles hold 8 ticks at /4 and 4 at /8, whatever the phase
		@(posedge core_clk);
		t1_clk_src <= iodt_pkg::CLK_SRC_SCALED;
		t2_clk_src <= iodt_pkg::CLK_SRC_SCALED;
		t1_en_src <= iodt_pkg::CLK_SRC_PIN;
		t2_en_src <= iodt_pkg::CLK_SRC_PIN;
		t1_en_level <= 1'b0;
		t2_en_level <= 1'b0;
		tick(2);
		ext_drv[7:4] <= 4'h0;
		tick(32);
		ext_drv[7:4] <= 4'hf;
		tick(2);
		cap();
		rd(1'b0, 16'h1224);
		rd(1'b1, 16'h0097);
		// Ordinary port cases
		foreach (rows[r]) begin
			@(posedge core_clk);
			gp_out_val <= rows[r][0];
			gp_dir_out <= rows[r][1];
			gp_pullup_cfg <= rows[r][2];
			ext_drv <= rows[r][3];
			ext_en <= ~rows[r][1];
			tick(3);
			#1;
			chk({4'h0, gp_read_val}, {4'h0, rows[r][4]});
			chk({4'h0, pin_pullup_en}, {4'h0, rows[r][5]});
		end
		// Detect latches: clear, catch a short low, set beats clear
		@(posedge core_clk);
		gp_dir_out <= 12'h000;
		ext_en <= 12'hfff;
		ext_drv <= 12'hfff;
		detect_clr <= 8'hff;
		tick(2);
		detect_clr <= 8'h00;
		ext_drv[2] <= 1'b0;
		tick(1);
		ext_drv[2] <= 1'b1;
		ext_drv[3] <= 1'b0;
		detect_clr[3] <= 1'b1;
		tick(3);
		#1;
		chk({8'h0, detect_flag}, 16'h000c);
		// Reset in mid-run clears flags, latch bytes and drive
		@(posedge core_clk);
		rst <= 1'b1;
		tick(2);
		#1;
		chk({detect_flag, t1_rd_data}, 16'h0000);
		chk({4'h0, pin_oe_n}, 16'h0fff);
		@(posedge core_clk);
		rst <= 1'b0;
		tick(2);
		#1;
		chk({8'h00, t2_rd_data}, 16'h0000);
		wrap_up();
	end
endmodule
`default_nettype wire
